// ==== common/uhp_pkg.sv ====
// Function
// - Strobe and multiplexed interrupt driven when output-enable bit set
// - Standard mode transmit idles high, also reset
// - Infrared mode transmit rests low when idle
// - Host sets request-to-send before auto flow
// - Clear-to-send gates transmit when enabled
// - Half-duplex strap makes request-to-send direction
// - Infrared strap selects infrared line mode
// - Four modem pins double as GPIO 0-3
// - Sleep input forces sleep after next byte
// - Sleep pin may output sleep status
// - Bus cycles timed only by host strobes
// - Strobe mode: 8 data, 3 address, active-high interrupt
// - Select mode: read/write line, open-drain low interrupt
// - Multiplexed mode shares address and data lines
// - Reset over 40 ns restores defaults
// - Strobe interrupt high above trigger or timeout
// - Select mode interrupt low above trigger or timeout
// - Multiplexed strap overrides bus-style select pin
// - Address latched on latch strobe rising edge
// - Write strobe rising edge stores data byte; in select mode chip-select rising edge does
package uhp_pkg;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 3;
    localparam int GPIO_W   = 4;
    // Register addresses
    localparam logic [2:0] ADDR_THR = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_FCR = 3'h2;
    localparam logic [2:0] ADDR_EFR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_GPS = 3'h7;
    // Field positions
    localparam int MCR_RTS  = 1;
    localparam int MCR_OE   = 3;
    localparam int MCR_IR   = 6;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int IER_RX   = 0;
    localparam int FCR_EN   = 0;
    localparam int MSR_CTS  = 4;
    localparam int LSR_SLP  = 7;
    localparam int LSR_TXI  = 6;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] TRIG_DEF = 8'h04;
    // Reset pulse
    localparam int RESET_MIN_NS = 40;
    localparam int CLK_NS       = 10;
    localparam int RESET_CYC    = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMEOUT_CYC  = 64;
    typedef enum logic [1:0] {BUS_STROBE, BUS_SELECT, BUS_MUX} uhp_bus_type;
endpackage

// ==== common/uhp_if.sv ====
`timescale 1ns/1ns
interface uhp_if;
    logic [7:0] data_host;
    logic       data_host_oe_n;
    logic [7:0] data_dev;
    logic       data_dev_oe_n;
    logic [2:0] addr;
    logic       cs_n;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic       addr_latch_n;
    logic       bus_style_sel;
    logic       muxed_bus_strap;
    logic       reset_pin;
    logic       irq;
    logic       irq_oe_n;
    modport dev  (input data_host, data_host_oe_n, addr, cs_n, read_strobe_n, write_strobe_n,
                  addr_latch_n, bus_style_sel, muxed_bus_strap, reset_pin,
                  output data_dev, data_dev_oe_n, irq, irq_oe_n);
    modport host (output data_host, data_host_oe_n, addr, cs_n, read_strobe_n, write_strobe_n,
                  addr_latch_n, bus_style_sel, muxed_bus_strap, reset_pin,
                  input data_dev, data_dev_oe_n, irq, irq_oe_n);
endinterface

// ==== hdl/uhp_device.sv ====
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
module uhp_device
    import uhp_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYC
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_resetn,
    uhp_if.dev                     bus,
    input  wire logic              i_half_duplex_strap_n,
    input  wire logic              i_infrared_strap_n,
    input  wire logic              i_rx,
    input  wire logic              i_cts_n,
    input  wire logic [GPIO_W-1:0] i_gpio,
    input  wire logic              i_sleep,
    input  wire logic              i_sleep_out_sel,
    input  wire logic              i_tx_busy,
    input  wire logic [7:0]        i_rx_level,
    input  wire logic              i_byte_done,
    output logic                   o_tx,
    output logic                   o_rts_n,
    output logic [GPIO_W-1:0]      o_gpio,
    output logic [GPIO_W-1:0]      o_gpio_oe_n,
    output logic                   o_power_down_out_n,
    output logic                   o_power_down_oe_n,
    output logic                   o_tx_stall
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Bus pins are asynchronous to this clock; the ref clock stands in for strobe timing
    localparam int NS = 10;
    logic [NS-1:0] s1_q, s2_q, s3_q;
    logic [NS-1:0] pins;
    assign pins = {bus.cs_n, bus.read_strobe_n, bus.write_strobe_n, bus.addr_latch_n,
                   bus.bus_style_sel, bus.muxed_bus_strap, bus.reset_pin, i_cts_n, i_sleep, i_rx};
    always_ff @(posedge i_ref_clk) begin
        s1_q <= pins;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    logic cs_n, rd_n, wr_n, al_n, sel, mstrap, rpin, cts_n, slp;
    assign {cs_n, rd_n, wr_n, al_n, sel, mstrap, rpin, cts_n, slp} = s2_q[NS-1:1];
    logic rd_prev_n, wr_prev_n, al_prev_n;
    assign {rd_prev_n, wr_prev_n, al_prev_n} = s3_q[8:6];
    // Address, data, straps and GPIO pins pass the same two stages as the strobes; the third
    // data stage still holds the muxed address that stood before the latch strobe rose
    logic [DATA_W-1:0] d1_q, d2_q, d3_q;
    logic [ADDR_W-1:0] a1_q, a2_q;
    logic [GPIO_W+1:0] x1_q, x2_q;
    always_ff @(posedge i_ref_clk) begin
        d1_q <= bus.data_host;
        d2_q <= d1_q;
        d3_q <= d2_q;
        a1_q <= bus.addr;
        a2_q <= a1_q;
        x1_q <= {i_gpio, i_half_duplex_strap_n, i_infrared_strap_n};
        x2_q <= x1_q;
    end

    // Bus style from straps
    uhp_bus_type mode;
    always_comb begin
        if (mstrap)
            mode = BUS_MUX;
        else if (sel)
            mode = BUS_STROBE;
        else
            mode = BUS_SELECT;
    end

    // Reset pin polarity follows bus style, counted to the minimum width
    logic       rst_act;
    logic [3:0] rcnt_q;
    logic       pin_rst_q;
    assign rst_act = (mode == BUS_SELECT) ? !rpin : rpin;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || !rst_act)
            rcnt_q <= 4'h0;
        else if (rcnt_q != 4'(RESET_CYC))
            rcnt_q <= rcnt_q + 4'h1;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn)
            pin_rst_q <= 1'b0;
        else
            pin_rst_q <= rst_act && (rcnt_q >= 4'(RESET_CYC - 1));
    end
    logic srst;
    assign srst = !i_resetn || pin_rst_q;

    // ----------------------------------------
    // Straps, caught after reset release
    // ----------------------------------------
    logic strap_done_q, hd_strap_q;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            strap_done_q <= 1'b0;
            hd_strap_q   <= 1'b1;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            hd_strap_q   <= x2_q[1];
        end
    end

    // ----------------------------------------
    // Host register access
    // ----------------------------------------
    logic [2:0] addr_q;
    logic [7:0] ier_q, fcr_q, efr_q, mcr_q, gdir_q, gout_q;
    logic       rd_edge_f, rd_edge_r, wr_edge_r, rw_write;
    logic [2:0] eff_addr;
    // In select mode the write-strobe pin is the read/write line, cs frames the cycle
    assign rw_write  = (mode == BUS_SELECT) && !wr_n;
    assign rd_edge_f = (mode == BUS_SELECT) ? (!cs_n && !rw_write) : (!cs_n && !rd_n && rd_prev_n);
    assign rd_edge_r = !rd_prev_n && rd_n;
    assign wr_edge_r = (mode == BUS_SELECT) ? (cs_n && s3_q[9] == 1'b0 && !wr_prev_n)
                                            : (!s3_q[9] && wr_n && !wr_prev_n);
    // Chip select may rise together with the strobe, so the write looks at its previous level
    assign eff_addr  = (mode == BUS_MUX) ? addr_q : a2_q;

    always_ff @(posedge i_ref_clk) begin
        if (srst)
            addr_q <= 3'h0;
        else if (mode == BUS_MUX && al_n && !al_prev_n)
            addr_q <= d3_q[ADDR_W-1:0];
    end

    always_ff @(posedge i_ref_clk) begin
        if (srst) begin
            ier_q  <= RST_ZERO;
            fcr_q  <= RST_ZERO;
            efr_q  <= RST_ZERO;
            gdir_q <= RST_ZERO;
            gout_q <= RST_ZERO;
            mcr_q  <= RST_ZERO;
        end else if (!strap_done_q) begin
            mcr_q[MCR_IR] <= !x2_q[0];
        end else if (wr_edge_r) begin
            case (eff_addr)
                ADDR_IER: ier_q  <= d2_q;
                ADDR_FCR: fcr_q  <= d2_q;
                ADDR_EFR: efr_q  <= d2_q;
                ADDR_MCR: mcr_q  <= d2_q;
                ADDR_GPS: {gdir_q[3:0], gout_q[3:0]} <= d2_q;
                default:  ;
            endcase
        end
    end

    // ----------------------------------------
    // Sleep
    // ----------------------------------------
    logic sleep_req_q, asleep_q;
    always_ff @(posedge i_ref_clk) begin
        if (srst) begin
            sleep_req_q <= 1'b0;
            asleep_q    <= 1'b0;
        end else begin
            if (slp && !i_sleep_out_sel)
                sleep_req_q <= 1'b1;
            if (sleep_req_q && i_byte_done) begin
                asleep_q    <= 1'b1;
                sleep_req_q <= 1'b0;
            end else if (!slp && !sleep_req_q)
                asleep_q    <= 1'b0;
        end
    end

    // ----------------------------------------
    // Receive interrupt
    // ----------------------------------------
    logic [7:0] tcnt_q;
    logic       above, tmo, irq_cond;
    assign above = i_rx_level > TRIG_DEF;
    always_ff @(posedge i_ref_clk) begin
        if (srst || i_rx_level == 8'h00 || rd_edge_f)
            tcnt_q <= 8'h00;
        else if (tcnt_q != 8'(TIMEOUT))
            tcnt_q <= tcnt_q + 8'h01;
    end
    assign tmo      = tcnt_q == 8'(TIMEOUT);
    assign irq_cond = ier_q[IER_RX] && (fcr_q[FCR_EN] ? (above || tmo) : (i_rx_level != 8'h00));

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [7:0] rdata;
    always_comb begin
        case (eff_addr)
            ADDR_IER: rdata = ier_q;
            ADDR_FCR: rdata = fcr_q;
            ADDR_EFR: rdata = efr_q;
            ADDR_MCR: rdata = mcr_q;
            ADDR_LSR: rdata = {asleep_q, i_tx_busy, 6'h00};
            ADDR_MSR: rdata = {3'h0, !cts_n, 4'h0};
            ADDR_GPS: rdata = {x2_q[GPIO_W+1:2], gout_q[3:0]};
            default:  rdata = RST_ZERO;
        endcase
    end
    always_ff @(posedge i_ref_clk) begin
        if (srst) begin
            bus.data_dev      <= RST_ZERO;
            bus.data_dev_oe_n <= 1'b1;
            bus.irq           <= 1'b0;
            bus.irq_oe_n      <= 1'b1;
            o_tx              <= 1'b1;
            o_rts_n           <= 1'b1;
            o_gpio            <= 4'h0;
            o_gpio_oe_n       <= 4'hF;
            o_power_down_out_n <= 1'b1;
            o_power_down_oe_n <= 1'b1;
            o_tx_stall        <= 1'b0;
        end else begin
            if (rd_edge_f)
                bus.data_dev <= rdata;
            bus.data_dev_oe_n <= !(rd_edge_f || (!bus.data_dev_oe_n && !rd_edge_r && !cs_n));
            if (mode == BUS_SELECT) begin
                bus.irq      <= 1'b0;
                bus.irq_oe_n <= !irq_cond;
            end else begin
                bus.irq      <= irq_cond;
                bus.irq_oe_n <= !mcr_q[MCR_OE];
            end
            if (i_tx_busy)
                o_tx <= 1'b0;
            else
                o_tx <= !mcr_q[MCR_IR];
            if (!hd_strap_q)
                o_rts_n <= !i_tx_busy;
            else
                o_rts_n <= !mcr_q[MCR_RTS];
            o_tx_stall <= efr_q[EFR_ACTS] && cts_n;
            o_gpio      <= gout_q[3:0];
            o_gpio_oe_n <= ~gdir_q[3:0];
            o_power_down_out_n <= !asleep_q;
            o_power_down_oe_n  <= !i_sleep_out_sel;
        end
    end
endmodule

// ==== hdl/uhp_host.sv ====
`timescale 1ns/1ns
module uhp_host
    import uhp_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_resetn,
    uhp_if.host             bus,
    input  wire logic [1:0] i_style,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_dev_reset,
    output logic [7:0]      o_rdata,
    output logic            o_busy,
    output logic            o_done,
    output logic            o_irq
);
    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    typedef enum {IDLE, LATCH, SETUP, HOLD, END} uhp_st_type;
    uhp_st_type st_q;
    logic       write_q;
    logic [2:0] cnt_q;
    logic [2:0] rst_q;
    logic       i1_q, i2_q;
    localparam logic [2:0] PHASE = 3'h3;

    always_ff @(posedge i_ref_clk) begin
        i1_q  <= bus.irq_oe_n ? 1'b0 : bus.irq;
        i2_q  <= i1_q;
        o_irq <= (i_style == 2'h1) ? !bus.irq_oe_n : i2_q;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn)
            rst_q <= 3'h0;
        else if (i_dev_reset)
            rst_q <= 3'(RESET_CYC + 1);
        else if (rst_q != 3'h0)
            rst_q <= rst_q - 3'h1;
        bus.reset_pin <= (i_style == 2'h1) ? (rst_q == 3'h0) : (rst_q != 3'h0);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            st_q               <= IDLE;
            write_q            <= 1'b0;
            cnt_q              <= 3'h0;
            bus.cs_n           <= 1'b1;
            bus.read_strobe_n  <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            bus.addr_latch_n   <= 1'b1;
            bus.addr           <= 3'h0;
            bus.data_host      <= RST_ZERO;
            bus.data_host_oe_n <= 1'b1;
            bus.bus_style_sel  <= 1'b1;
            bus.muxed_bus_strap <= 1'b0;
            o_rdata            <= RST_ZERO;
            o_busy             <= 1'b0;
            o_done             <= 1'b0;
        end else begin
            bus.bus_style_sel   <= (i_style == 2'h0);
            bus.muxed_bus_strap <= (i_style == 2'h2);
            o_done <= 1'b0;
            if (cnt_q != 3'h0)
                cnt_q <= cnt_q - 3'h1;
            case (st_q)
                IDLE: if (i_wr || i_rd) begin
                    write_q  <= i_wr;
                    o_busy   <= 1'b1;
                    bus.addr <= i_addr;
                    bus.data_host <= (i_style == 2'h2) ? {5'h00, i_addr} : i_wdata;
                    cnt_q    <= PHASE;
                    if (i_style == 2'h2) begin
                        bus.data_host_oe_n <= 1'b0;
                        bus.addr_latch_n   <= 1'b0;
                        bus.cs_n           <= 1'b0;
                        st_q <= LATCH;
                    end else begin
                        bus.data_host_oe_n <= !i_wr;
                        bus.write_strobe_n <= (i_style == 2'h1) ? !i_wr : 1'b1;
                        st_q <= SETUP;
                    end
                end
                LATCH: if (cnt_q == 3'h0) begin
                    bus.addr_latch_n   <= 1'b1;
                    bus.data_host      <= i_wdata;
                    bus.data_host_oe_n <= !write_q;
                    cnt_q <= PHASE;
                    st_q  <= SETUP;
                end
                SETUP: if (cnt_q == 3'h0) begin
                    bus.cs_n <= 1'b0;
                    if (i_style != 2'h1) begin
                        bus.read_strobe_n  <= write_q;
                        bus.write_strobe_n <= !write_q;
                    end
                    cnt_q <= PHASE + PHASE;
                    st_q  <= HOLD;
                end
                HOLD: if (cnt_q == 3'h0) begin
                    if (!write_q)
                        o_rdata <= bus.data_dev;
                    bus.read_strobe_n  <= 1'b1;
                    bus.write_strobe_n <= 1'b1;
                    bus.cs_n           <= 1'b1;
                    cnt_q <= PHASE;
                    st_q  <= END;
                end
                END: if (cnt_q == 3'h0) begin
                    bus.data_host_oe_n <= 1'b1;
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    st_q   <= IDLE;
                end
                default: st_q <= IDLE;
            endcase
        end
    end
endmodule

// ==== tb/uhp_props.sv ====
`timescale 1ns/1ns
module uhp_props (
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    input  wire logic data_host_oe_n,
    input  wire logic data_dev_oe_n,
    input  wire logic cs_n,
    input  wire logic read_strobe_n,
    input  wire logic write_strobe_n,
    input  wire logic addr_latch_n,
    input  wire logic bus_style_sel,
    input  wire logic muxed_bus_strap,
    input  wire logic reset_pin,
    input  wire logic irq,
    input  wire logic irq_oe_n
);
    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    logic strobe_mode;
    logic pin_rst;
    assign strobe_mode = bus_style_sel | muxed_bus_strap;
    // Reset pin polarity follows the bus style
    assign pin_rst     = strobe_mode ? reset_pin : !reset_pin;

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_NO_CONTENTION: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !(!data_host_oe_n && !data_dev_oe_n)) else $error("both ends drive the data lines");
    AST_IDLE_RELEASE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        cs_n [*4] |-> data_dev_oe_n) else $error("device drives data while deselected");
    AST_WRITE_DRIVE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !cs_n && !write_strobe_n && read_strobe_n |-> !data_host_oe_n) else $error("write without host data");
    AST_ONE_STROBE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        strobe_mode && !cs_n |-> read_strobe_n || write_strobe_n) else $error("both strobes low");
    AST_STROBE_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        strobe_mode && $fell(write_strobe_n) |-> !write_strobe_n [*4]) else $error("write strobe too short");
    AST_LATCH_FIRST: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        muxed_bus_strap && ($fell(read_strobe_n) || $fell(write_strobe_n)) |-> addr_latch_n)
        else $error("strobe before address latched");
    AST_OD_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !strobe_mode && !irq_oe_n |-> !irq) else $error("open drain interrupt drives high");
    AST_PIN_RESET: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        pin_rst [*5] |-> ##3 (irq_oe_n && data_dev_oe_n)) else $error("pin reset left outputs driven");
    AST_SYNC_RESET: assert property (@(posedge i_ref_clk)
        !i_resetn |=> irq_oe_n && data_dev_oe_n) else $error("reset left outputs driven");
endmodule

// ==== tb/test_uart_host_port_and_pin_modes.sv ====
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module test_uart_host_port_and_pin_modes;
    import uhp_pkg::*;
    typedef struct packed {logic [1:0] st; logic [2:0] a; logic [7:0] d;} uhp_row_type;
    logic i_ref_clk, i_resetn, hd_n, ir_n, rx, cts_n, sleep, sleep_sel, tx_busy, byte_done;
    logic wr, rd, dev_rst, tx, rts_n, pd_n, pd_oe_n, tx_stall, busy, done, irq_h;
    logic [3:0] gpio_in, gpio_o, gpio_oe_n;
    logic [7:0] rx_level, wdata, rdata;
    logic [1:0] style;
    logic [2:0] addr;
    int mismatches = 0;
    int num_checks = 0;
    uhp_row_type rows [6] = '{'{2'd0, ADDR_IER, 8'h01}, '{2'd1, ADDR_MCR, 8'h02}, '{2'd2, ADDR_EFR, 8'h40},
                              '{2'd0, ADDR_MCR, 8'h0A}, '{2'd1, ADDR_IER, 8'h00}, '{2'd2, ADDR_EFR, 8'h00}};

    uhp_if u_if();
    uhp_device #(.TIMEOUT(8)) uhp_device_inst (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .bus(u_if),
        .i_half_duplex_strap_n(hd_n), .i_infrared_strap_n(ir_n), .i_rx(rx), .i_cts_n(cts_n), .i_gpio(gpio_in),
        .i_sleep(sleep), .i_sleep_out_sel(sleep_sel), .i_tx_busy(tx_busy), .i_rx_level(rx_level),
        .i_byte_done(byte_done), .o_tx(tx), .o_rts_n(rts_n), .o_gpio(gpio_o), .o_gpio_oe_n(gpio_oe_n),
        .o_power_down_out_n(pd_n), .o_power_down_oe_n(pd_oe_n), .o_tx_stall(tx_stall));
    uhp_host uhp_host_inst (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .bus(u_if), .i_style(style), .i_wr(wr),
        .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_dev_reset(dev_rst), .o_rdata(rdata), .o_busy(busy),
        .o_done(done), .o_irq(irq_h));
    uhp_props uhp_props_inst (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .data_host_oe_n(u_if.data_host_oe_n),
        .data_dev_oe_n(u_if.data_dev_oe_n), .cs_n(u_if.cs_n), .read_strobe_n(u_if.read_strobe_n),
        .write_strobe_n(u_if.write_strobe_n), .addr_latch_n(u_if.addr_latch_n), .bus_style_sel(u_if.bus_style_sel),
        .muxed_bus_strap(u_if.muxed_bus_strap), .reset_pin(u_if.reset_pin), .irq(u_if.irq), .irq_oe_n(u_if.irq_oe_n));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic host_op(input logic [1:0] st, input logic w, input logic [2:0] a, input logic [7:0] d);
        int n;
        @(posedge i_ref_clk);
        style <= st;
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge i_ref_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        `CHK("host done", 1'b1, done)
    endtask

    // Covers the two to three cycle synchroniser lag on the device side
    task automatic wait_sync;
        repeat (6) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        mismatches++;
        $display("watchdog expired");
        stop_test;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {i_resetn, hd_n, ir_n, rx, cts_n, sleep, sleep_sel, tx_busy, byte_done} = 9'b011100000;
        {wr, rd, dev_rst, style, addr, wdata, rx_level} = '0;
        gpio_in = 4'hA;
        repeat (11) @(posedge i_ref_clk);
        #1;
        `CHK("tx in reset", 1'b1, tx)
        @(posedge i_ref_clk) i_resetn <= 1'b1;
        foreach (rows[i]) begin
            host_op(rows[i].st, 1'b1, rows[i].a, rows[i].d);
            host_op(rows[i].st, 1'b0, rows[i].a, 8'h00);
            `CHK("readback", rows[i].d, rdata)
        end
        wait_sync;
        `CHK("rts general output", 1'b0, rts_n)
        `CHK("tx idle", 1'b1, tx)
        host_op(2'd0, 1'b1, ADDR_MCR, 8'h00);
        wait_sync;
        `CHK("irq released", 1'b1, u_if.irq_oe_n)
        host_op(2'd0, 1'b1, ADDR_MCR, 8'h08);
        host_op(2'd0, 1'b1, ADDR_FCR, 8'h01);
        host_op(2'd0, 1'b1, ADDR_IER, 8'h01);
        wait_sync;
        `CHK("irq driven", 1'b0, u_if.irq_oe_n)
        `CHK("irq below trigger", 1'b0, u_if.irq)
        @(posedge i_ref_clk) rx_level <= 8'h06;
        wait_sync;
        `CHK("irq above trigger", 1'b1, u_if.irq)
        `CHK("host irq", 1'b1, irq_h)
        @(posedge i_ref_clk) rx_level <= 8'h02;
        repeat (40) @(posedge i_ref_clk);
        #1;
        `CHK("irq on timeout", 1'b1, u_if.irq)
        @(posedge i_ref_clk) rx_level <= 8'h00;
        host_op(2'd1, 1'b0, ADDR_IER, 8'h00);
        wait_sync;
        `CHK("select irq released", 1'b1, u_if.irq_oe_n)
        @(posedge i_ref_clk) rx_level <= 8'h06;
        wait_sync;
        `CHK("select irq pulls low", 1'b0, u_if.irq_oe_n)
        `CHK("select host irq", 1'b1, irq_h)
        @(posedge i_ref_clk) rx_level <= 8'h00;
        host_op(2'd0, 1'b1, ADDR_EFR, 8'h80);
        @(posedge i_ref_clk) cts_n <= 1'b1;
        wait_sync;
        `CHK("stall on cts", 1'b1, tx_stall)
        @(posedge i_ref_clk) cts_n <= 1'b0;
        wait_sync;
        `CHK("resume on cts", 1'b0, tx_stall)
        host_op(2'd0, 1'b1, ADDR_GPS, 8'hF5);
        wait_sync;
        `CHK("gpio out", 4'h5, gpio_o)
        `CHK("gpio dir", 4'h0, gpio_oe_n)
        host_op(2'd0, 1'b1, ADDR_MCR, 8'h40);
        @(posedge i_ref_clk) rx <= 1'b0;
        wait_sync;
        `CHK("ir tx rest", 1'b0, tx)
        @(posedge i_ref_clk) sleep <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        byte_done <= 1'b1;
        @(posedge i_ref_clk) byte_done <= 1'b0;
        sleep_sel <= 1'b1;
        wait_sync;
        `CHK("sleep pin output", 1'b0, pd_oe_n)
        `CHK("sleep shown", 1'b0, pd_n)
        host_op(2'd0, 1'b0, ADDR_LSR, 8'h00);
        `CHK("asleep flag", 1'b1, rdata[LSR_SLP])
        @(posedge i_ref_clk) dev_rst <= 1'b1;
        @(posedge i_ref_clk) dev_rst <= 1'b0;
        rx <= 1'b1;
        repeat (12) @(posedge i_ref_clk);
        host_op(2'd0, 1'b0, ADDR_MCR, 8'h00);
        `CHK("mcr after pin reset", 8'h00, rdata)
        `CHK("tx after pin reset", 1'b1, tx)
        @(posedge i_ref_clk) i_resetn <= 1'b0;
        {ir_n, hd_n, rx, sleep} <= 4'b0000;
        repeat (12) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        host_op(2'd0, 1'b0, ADDR_MCR, 8'h00);
        `CHK("ir default", 1'b1, rdata[MCR_IR])
        `CHK("ir tx idle", 1'b0, tx)
        `CHK("rs485 idle", 1'b1, rts_n)
        @(posedge i_ref_clk) tx_busy <= 1'b1;
        wait_sync;
        `CHK("rs485 direction", 1'b0, rts_n)
        stop_test;
    end
endmodule
